/* logic/tdl_regs.svh */
`ifndef TDL_REGS_SVH
`define TDL_REGS_SVH
`define TDL_GCR_WIDTH 32
`define TDL_GCR_ARM_BIT 16
`define TDL_GCR_ARM_MASK 32'h0001_0000
`define TDL_GCR_RESET 32'h0000_0000
`define TDL_SYNC_STAGES 3
`endif

/* logic/tdl_pkg.sv */
package tdl_pkg;
    typedef enum logic [0:0] {
        TDL_DISARMED = 1'b0,
        TDL_ARMED = 1'b1
    } tdl_arm_state_t;
endpackage : tdl_pkg

/* logic/tdl_sync.sv */
`timescale 1ns/1ps
`include "tdl_regs.svh"
module tdl_sync (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic async_i,
    output logic level_o
);
    logic [`TDL_SYNC_STAGES-1:0] stage;
    logic [`TDL_SYNC_STAGES-1:0] next_stage;
    logic level;
    logic next_level;

    // The first stage feeds only the second; the filter compares the later two.
    always_comb begin
        next_stage = {stage[`TDL_SYNC_STAGES-2:0], async_i};
        next_level = level;
        if (stage[1] == stage[2]) begin
            next_level = stage[1];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            stage <= '0;
            level <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end

    assign level_o = level;
endmodule : tdl_sync

/* logic/tdl_tamper_latch.sv */
`timescale 1ns/1ps
`include "tdl_regs.svh"
// Function
// - Armed logic with tamper input asserted raises the security violation output.
// - Violation goes only to the security monitor path, never a peripheral interrupt.
// - Reset clears the arm flag, so no violation until software arms.
// - Software cannot clear the arm flag; only reset clears it.
// - Arm flag lives at bit 16 of the general control register.
// - Tamper pin keeps normal GPIO sampling at pad_sample_o, armed or disarmed.
module tdl_tamper_latch
    import tdl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic tamper_input_pin_i,
    input wire logic gcr_wr_i,
    input wire logic [`TDL_GCR_WIDTH-1:0] gcr_wdata_i,
    output logic [`TDL_GCR_WIDTH-1:0] general_control_register_o,
    output logic tamper_armed_o,
    output logic pad_sample_o,
    output logic security_violation_o
);
    logic tamper_level;
    tdl_arm_state_t arm_state;
    tdl_arm_state_t next_arm_state;
    logic [`TDL_GCR_WIDTH-1:0] gcr;
    logic [`TDL_GCR_WIDTH-1:0] next_gcr;
    wire logic [`TDL_GCR_WIDTH-1:0] store_word;
    logic violation;
    logic next_violation;
    logic pad_sample;
    logic next_pad_sample;
    logic arm_request;

    // The arm flag and the violation path both ask the same question of the state.
    function automatic logic is_armed(input tdl_arm_state_t state);
        return state == TDL_ARMED;
    endfunction : is_armed

    tdl_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(tamper_input_pin_i),
        .level_o(tamper_level)
    );

    // Every bit other than the arm flag is plain storage that takes the written value.
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < `TDL_GCR_WIDTH; bit_idx = bit_idx + 1) begin : g_store
            assign store_word[bit_idx] = gcr_wr_i ? gcr_wdata_i[bit_idx] : gcr[bit_idx];
        end
    endgenerate

    // Arm state only moves forward; a write of zero to the bit has no effect.
    always_comb begin
        arm_request = gcr_wr_i && gcr_wdata_i[`TDL_GCR_ARM_BIT];
        next_arm_state = arm_state;
        unique case (arm_state)
            TDL_DISARMED: begin
                if (arm_request) begin
                    next_arm_state = TDL_ARMED;
                end
            end
            TDL_ARMED: begin
                next_arm_state = TDL_ARMED;
            end
        endcase
        next_gcr = store_word;
        next_gcr[`TDL_GCR_ARM_BIT] = is_armed(next_arm_state);
        next_violation = is_armed(arm_state) && tamper_level;
        next_pad_sample = tamper_level;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            arm_state <= TDL_DISARMED;
            gcr <= `TDL_GCR_RESET;
            violation <= 1'b0;
            pad_sample <= 1'b0;
        end else begin
            arm_state <= next_arm_state;
            gcr <= next_gcr;
            violation <= next_violation;
            pad_sample <= next_pad_sample;
        end
    end

    assign general_control_register_o = gcr;
    assign tamper_armed_o = gcr[`TDL_GCR_ARM_BIT];
    assign pad_sample_o = pad_sample;
    assign security_violation_o = violation;

    property p_no_viol_disarmed;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !$past(arm_state == TDL_ARMED) |-> !security_violation_o;
    endproperty
    a_no_viol_disarmed: assert property (p_no_viol_disarmed)
        else $error("Violation raised while disarmed.");

    property p_viol_follows;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (arm_state == TDL_ARMED && tamper_level) |=> security_violation_o;
    endproperty
    a_viol_follows: assert property (p_viol_follows)
        else $error("Armed tamper did not raise violation.");

    property p_sticky;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        tamper_armed_o |=> tamper_armed_o;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Arm flag cleared without reset.");

    property p_arm_write;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (gcr_wr_i && gcr_wdata_i[`TDL_GCR_ARM_BIT]) |=> tamper_armed_o;
    endproperty
    a_arm_write: assert property (p_arm_write)
        else $error("Write to bit 16 did not arm.");

    property p_reset_clear;
        @(posedge sys_clk_i) sys_rst_i |=> !tamper_armed_o && !security_violation_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Reset did not clear arm flag.");

    property p_pad_sample;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ##1 pad_sample_o == $past(tamper_level);
    endproperty
    a_pad_sample: assert property (p_pad_sample)
        else $error("Pad sample does not track pin.");

    property p_viol_needs_pin;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        security_violation_o |-> $past(tamper_level);
    endproperty
    a_viol_needs_pin: assert property (p_viol_needs_pin)
        else $error("Violation without tamper input.");

    property p_self_arm;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!tamper_armed_o && !gcr_wr_i) |=> !tamper_armed_o;
    endproperty
    a_self_arm: assert property (p_self_arm)
        else $error("Arm flag set without write.");

    property p_gcr_store;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        gcr_wr_i |=> (general_control_register_o | `TDL_GCR_ARM_MASK) ==
            ($past(gcr_wdata_i) | `TDL_GCR_ARM_MASK);
    endproperty
    a_gcr_store: assert property (p_gcr_store)
        else $error("Register did not store the written word.");

    property p_gcr_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !gcr_wr_i |=> $stable(general_control_register_o);
    endproperty
    a_gcr_hold: assert property (p_gcr_hold)
        else $error("Register changed without a write.");

    property p_arm_zero_write;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (tamper_armed_o && gcr_wr_i && !gcr_wdata_i[`TDL_GCR_ARM_BIT]) |=> tamper_armed_o;
    endproperty
    a_arm_zero_write: assert property (p_arm_zero_write)
        else $error("Write of zero cleared the arm flag.");

    property p_arm_rise;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!tamper_armed_o && gcr_wr_i && gcr_wdata_i[`TDL_GCR_ARM_BIT])
            |=> $rose(tamper_armed_o);
    endproperty
    a_arm_rise: assert property (p_arm_rise)
        else $error("Arm write did not raise the flag in one cycle.");

    property p_armed_match;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        tamper_armed_o == is_armed(arm_state);
    endproperty
    a_armed_match: assert property (p_armed_match)
        else $error("Arm flag output disagrees with arm state.");

    property p_reset_store;
        @(posedge sys_clk_i)
        sys_rst_i |=> (general_control_register_o == `TDL_GCR_RESET) && !pad_sample_o;
    endproperty
    a_reset_store: assert property (p_reset_store)
        else $error("Reset did not clear register and pad sample.");

    property p_viol_drop;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !tamper_level |=> !security_violation_o;
    endproperty
    a_viol_drop: assert property (p_viol_drop)
        else $error("Violation stayed after tamper input fell.");

    property p_viol_armed_pin;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        security_violation_o |-> $past(tamper_armed_o);
    endproperty
    a_viol_armed_pin: assert property (p_viol_armed_pin)
        else $error("Violation raised without the arm flag.");

    property p_viol_level;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (security_violation_o && tamper_level) |=> security_violation_o;
    endproperty
    a_viol_level: assert property (p_viol_level)
        else $error("Violation fell while armed with tamper input high.");

    property p_disarmed_silent;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !tamper_armed_o |=> !security_violation_o;
    endproperty
    a_disarmed_silent: assert property (p_disarmed_silent)
        else $error("Violation followed a disarmed cycle.");

    property p_pad_disarmed;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!tamper_armed_o && tamper_level) |=> pad_sample_o;
    endproperty
    a_pad_disarmed: assert property (p_pad_disarmed)
        else $error("Pad sample missed the pin while disarmed.");

    property p_pad_armed;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (tamper_armed_o && !tamper_level) |=> !pad_sample_o;
    endproperty
    a_pad_armed: assert property (p_pad_armed)
        else $error("Pad sample missed the pin while armed.");
endmodule : tdl_tamper_latch

/* tb/tdl_switch_model.sv */
`timescale 1ns/1ps
module tdl_switch_model (
    input wire logic sys_clk_i,
    input wire logic press_i,
    output logic pin_o
);
    // Contact bounce is left out; the latch only ever sees a clean level.
    always @(posedge sys_clk_i) begin
        pin_o <= press_i;
    end
endmodule : tdl_switch_model

/* tb/tdl_tamper_latch_tb_top.sv */
`timescale 1ns/1ps
module tdl_tamper_latch_tb_top;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic press = 1'b0;
    logic gcr_wr = 1'b0;
    logic [31:0] gcr_wdata = 32'h0;
    logic [31:0] gcr, word, g;
    logic pin, armed, pad, viol, a, p;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    tdl_switch_model SW (.sys_clk_i(sys_clk_i), .press_i(press), .pin_o(pin));
    tdl_tamper_latch DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .tamper_input_pin_i(pin), .gcr_wr_i(gcr_wr), .gcr_wdata_i(gcr_wdata),
        .general_control_register_o(gcr), .tamper_armed_o(armed),
        .pad_sample_o(pad), .security_violation_o(viol));
    // The arm bit can only be set by a write, never cleared by one.
    function automatic logic [31:0] exp_gcr(input logic was, input logic [31:0] w);
        return w | {15'h0, was, 16'h0};
    endfunction : exp_gcr
    // Violation needs both the arm flag and the pin; the pad sample needs only the pin.
    function automatic logic [2:0] exp_flags(input logic arm, input logic pin_hi);
        return {arm & pin_hi, pin_hi, arm};
    endfunction : exp_flags
    task automatic chk_word(input logic [31:0] exp);
        check_count++;
        if (gcr !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, gcr, exp);
        end
    endtask : chk_word
    task automatic chk_flags(input logic [2:0] exp);
        check_count++;
        if ({viol, pad, armed} !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, {viol, pad, armed}, exp);
        end
    endtask : chk_flags
    task automatic press_at(input logic v);
        @(posedge sys_clk_i);
        press <= v;
    endtask : press_at
    task automatic wr(input logic [31:0] w);
        @(posedge sys_clk_i);
        gcr_wr <= 1'b1;
        gcr_wdata <= w;
        @(posedge sys_clk_i);
        gcr_wr <= 1'b0;
    endtask : wr
    task automatic wait_sync;
        repeat (7) @(posedge sys_clk_i);
        #1;
    endtask : wait_sync
    task automatic rst;
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        wait_sync();
    endtask : rst
    task automatic end_sim;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32'h17675f80));
        rst();
        chk_word(32'h0);
        chk_flags(3'b000);
        press_at(1'b1);
        wait_sync();
        chk_word(32'h0);
        chk_flags(exp_flags(1'b0, 1'b1));
        a = 1'b0;
        g = 32'h0;
        for (int i = 0; i < 8; i++) begin
            word = $urandom;
            if (i == 4) word = 32'h0;
            word[16] = (i == 3) ? 1'b1 : (i < 3 || i == 5) ? 1'b0 : word[16];
            p = (i != 6);
            press_at(p);
            wr(word);
            g = exp_gcr(a, word);
            a = g[16];
            wait_sync();
            chk_word(g);
            chk_flags(exp_flags(a, p));
        end
        // The pin is let go first, so the flushed synchroniser reads low after release.
        press_at(1'b0);
        rst();
        chk_word(32'h0);
        chk_flags(3'b000);
        press_at(1'b1);
        wait_sync();
        chk_word(32'h0);
        chk_flags(exp_flags(1'b0, 1'b1));
        end_sim();
    end
endmodule : tdl_tamper_latch_tb_top
